// File: msc_pkg.sv
// Constants shared by the motion sensor control register block.
// Overview of operation
// - State code reads 01 awake, 11 standby.
// - Status register resets 0x03, bits 6,4..2 zero.
// - Status bit 7 shows memory busy.
// - Enabled events drive the interrupt output.
// - Drop interrupt enabled only by drop control.
// - Any access drops interrupt; flags held until read.
// - Orientation fields refresh every sample, unlatched.
// - Enable reset 0x00; bits 0,1 orientation changes.
// - Enable bit 2 is tap; bit 3 reserved.
// - Enable bit 4 interrupts on every new sample.
// - Bits 7,6,5 gate shake flag per axis.
// - Mode register writable in wake and standby.
// - Request 01 wakes, 11 standby; reset 0x03.
// - Push-pull drives both levels, else open drain.
// - Active-high bit selects interrupt polarity.
// - Tap axis enables bits 5..7, reset 0x00.
// - Tap count k means k+1 sample periods.
// - Too long above threshold reports no tap.
// - Qualified tap sets flag, interrupts if enabled.
// - Latched flags stay until status is read.
// - No status updates during a bus transfer.
package msc_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] MOTION_STATUS_OFS   = 8'h03;
    localparam logic [7:0] OP_STATE_STATUS_OFS = 8'h04;
    localparam logic [7:0] INT_ENABLE_OFS      = 8'h06;
    localparam logic [7:0] DEVICE_MODE_OFS     = 8'h07;
    localparam logic [7:0] TAP_AXIS_EN_OFS     = 8'h09;
    localparam logic [7:0] TAP_PULSE_CNT_OFS   = 8'h0A;
    localparam logic [7:0] DROP_CONTROL_OFS    = 8'h0B;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] OP_STATE_RST   = 8'h03;
    localparam logic [7:0] INT_ENABLE_RST = 8'h00;
    localparam logic [7:0] MODE_RST       = 8'h03;
    localparam logic [7:0] TAP_AXIS_RST   = 8'h00;
    localparam logic [7:0] TAP_PULSE_RST  = 8'h00;
    localparam logic [7:0] DROP_CTL_RST   = 8'h00;
    // ------------------------------------------------------------
    // Field positions and codes
    // ------------------------------------------------------------
    localparam int         FB_IRQ_BIT      = 0;
    localparam int         ORIENT_IRQ_BIT  = 1;
    localparam int         TAP_IRQ_BIT     = 2;
    localparam int         SAMPLE_IRQ_BIT  = 4;
    localparam int         SHAKE_Z_BIT     = 5;
    localparam int         SHAKE_Y_BIT     = 6;
    localparam int         SHAKE_X_BIT     = 7;
    localparam int         PUSH_PULL_BIT   = 6;
    localparam int         ACTIVE_HIGH_BIT = 7;
    localparam int         TAP_X_BIT       = 5;
    localparam int         DROP_IRQ_BIT    = 6;
    localparam int         NVM_BUSY_BIT    = 7;
    localparam logic [1:0] STATE_WAKE      = 2'h1;
    localparam logic [1:0] STATE_STANDBY   = 2'h3;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam longint     CLK_HZ         = 200_000_000;
    localparam longint     SAMPLE_RATE_HZ = 1024;
    localparam int         SAMPLE_DIV     = int'(CLK_HZ / SAMPLE_RATE_HZ);
    localparam int         SYNC_STAGES    = 3;
endpackage

// File: msc_bus_monitor.sv
// Watches the serial bus pins for start and stop conditions.
module msc_bus_monitor (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      xfer_busy,
    output logic      xfer_start
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [msc_pkg::SYNC_STAGES-1:0] scl_sync_ff;
    logic [msc_pkg::SYNC_STAGES-1:0] sda_sync_ff;
    logic                            scl_ff;
    logic                            sda_ff;
    logic                            busy_ff;
    logic                            start_ff;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            scl_sync_ff <= '1;
            sda_sync_ff <= '1;
        end else begin
            scl_sync_ff <= {scl_sync_ff[1:0], scl_in};
            sda_sync_ff <= {sda_sync_ff[1:0], sda_in};
        end
    end

    // A pin level counts once the second and third stages agree.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            scl_ff <= 1'b1;
            sda_ff <= 1'b1;
        end else begin
            if (scl_sync_ff[1] == scl_sync_ff[2]) begin
                scl_ff <= scl_sync_ff[2];
            end
            if (sda_sync_ff[1] == sda_sync_ff[2]) begin
                sda_ff <= sda_sync_ff[2];
            end
        end
    end

    // ------------------------------------------------------------
    // Start and stop detection
    // ------------------------------------------------------------
    logic nxt_sda;
    logic sda_fall_hi;
    logic sda_rise_hi;
    always_comb begin
        nxt_sda     = (sda_sync_ff[1] == sda_sync_ff[2]) ? sda_sync_ff[2] : sda_ff;
        sda_fall_hi = scl_ff && sda_ff && !nxt_sda;
        sda_rise_hi = scl_ff && !sda_ff && nxt_sda;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            busy_ff  <= 1'b0;
            start_ff <= 1'b0;
        end else begin
            start_ff <= sda_fall_hi;
            if (sda_fall_hi) begin
                busy_ff <= 1'b1;
            end else if (sda_rise_hi) begin
                busy_ff <= 1'b0;
            end
        end
    end

    assign xfer_busy  = busy_ff;
    assign xfer_start = start_ff;
endmodule

// File: msc_ctrl_regs.sv
// Control and status registers of the motion sensor with interrupt pin.
module msc_ctrl_regs #(
    parameter int SAMPLE_DIV = msc_pkg::SAMPLE_DIV
) (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr_en,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_rd_en,
    output logic      [7:0] reg_rdata,
    input  wire logic       nvm_active,
    input  wire logic [2:0] shake_evt,
    input  wire logic       drop_evt,
    input  wire logic [2:0] tap_above,
    input  wire logic [2:0] orient_code,
    input  wire logic [1:0] face_code,
    output logic            sample_tick,
    output logic            irq_out_o,
    output logic            irq_out_oe
);
    // ------------------------------------------------------------
    // Bus activity
    // ------------------------------------------------------------
    logic xfer_busy;
    logic xfer_start;

    msc_bus_monitor u_mon (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .scl_in     (scl_in),
        .sda_in     (sda_in),
        .xfer_busy  (xfer_busy),
        .xfer_start (xfer_start)
    );

    // ------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------
    logic [7:0] int_en_ff;
    logic [7:0] mode_ff;
    logic       wake_ff;
    logic [2:0] tap_en_ff;
    logic [3:0] tap_cnt_ff;
    logic [7:0] drop_ctl_ff;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            int_en_ff   <= msc_pkg::INT_ENABLE_RST;
            mode_ff     <= msc_pkg::MODE_RST;
            tap_en_ff   <= msc_pkg::TAP_AXIS_RST[7:5];
            tap_cnt_ff  <= msc_pkg::TAP_PULSE_RST[3:0];
            drop_ctl_ff <= msc_pkg::DROP_CTL_RST;
        end else if (reg_wr_en) begin
            case (reg_addr)
                msc_pkg::INT_ENABLE_OFS: begin
                    int_en_ff <= reg_wdata & 8'hF7;
                end
                msc_pkg::DEVICE_MODE_OFS: begin
                    mode_ff <= reg_wdata & 8'hC3;
                end
                msc_pkg::TAP_AXIS_EN_OFS: begin
                    tap_en_ff <= reg_wdata[7:5];
                end
                msc_pkg::TAP_PULSE_CNT_OFS: begin
                    tap_cnt_ff <= reg_wdata[3:0];
                end
                msc_pkg::DROP_CONTROL_OFS: begin
                    drop_ctl_ff <= reg_wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // Reserved request codes leave the state unchanged.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wake_ff <= 1'b0;
        end else if (reg_wr_en && reg_addr == msc_pkg::DEVICE_MODE_OFS) begin
            if (reg_wdata[1:0] == msc_pkg::STATE_WAKE) begin
                wake_ff <= 1'b1;
            end else if (reg_wdata[1:0] == msc_pkg::STATE_STANDBY) begin
                wake_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Sample rate divider
    // ------------------------------------------------------------
    logic [31:0] div_ff;
    logic        tick_ff;

    always_ff @(posedge core_clk) begin
        if (!rst_n || !wake_ff) begin
            div_ff  <= 32'h0;
            tick_ff <= 1'b0;
        end else if (div_ff == 32'(SAMPLE_DIV - 1)) begin
            div_ff  <= 32'h0;
            tick_ff <= 1'b1;
        end else begin
            div_ff  <= div_ff + 32'h1;
            tick_ff <= 1'b0;
        end
    end

    assign sample_tick = tick_ff;

    // ------------------------------------------------------------
    // Tap duration filter
    // ------------------------------------------------------------
    logic [4:0] run_ff;
    logic       above;
    logic       tap_now;

    always_comb begin
        above   = |(tap_above & tap_en_ff);
        tap_now = tick_ff && !above && (run_ff == 5'({1'b0, tap_cnt_ff} + 5'h1));
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            run_ff <= 5'h0;
        end else if (tick_ff) begin
            if (!above) begin
                run_ff <= 5'h0;
            end else if (run_ff != 5'h11) begin
                run_ff <= run_ff + 5'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Event staging while the bus is busy
    // ------------------------------------------------------------
    logic [5:0] stg_ev_ff;
    logic [2:0] stg_pl_ff;
    logic [1:0] stg_fb_ff;
    logic       stg_new_ff;
    logic [5:0] ev_now;
    logic       apply;

    // Event bits: 0 face change, 1 orient change, 2 tap, 3 shake, 4 drop, 5 sample.
    always_comb begin
        ev_now    = 6'h0;
        ev_now[0] = tick_ff && (face_code != stg_fb_ff);
        ev_now[1] = tick_ff && (orient_code != stg_pl_ff);
        ev_now[2] = tap_now;
        ev_now[3] = tick_ff && |(shake_evt & {int_en_ff[msc_pkg::SHAKE_Z_BIT],
                    int_en_ff[msc_pkg::SHAKE_Y_BIT], int_en_ff[msc_pkg::SHAKE_X_BIT]});
        ev_now[4] = tick_ff && drop_evt;
        ev_now[5] = tick_ff;
        apply     = stg_new_ff && !xfer_busy;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            stg_ev_ff  <= 6'h0;
            stg_pl_ff  <= 3'h0;
            stg_fb_ff  <= 2'h0;
            stg_new_ff <= 1'b0;
        end else begin
            stg_ev_ff  <= (apply ? 6'h0 : stg_ev_ff) | ev_now;
            stg_new_ff <= (stg_new_ff && !apply) || tick_ff;
            if (tick_ff) begin
                stg_pl_ff <= orient_code;
                stg_fb_ff <= face_code;
            end
        end
    end

    // ------------------------------------------------------------
    // Motion status
    // ------------------------------------------------------------
    logic       shake_flag_ff;
    logic       drop_flag_ff;
    logic       tap_flag_ff;
    logic [2:0] pl_ff;
    logic [1:0] fb_ff;
    logic       status_rd;

    assign status_rd = reg_rd_en && reg_addr == msc_pkg::MOTION_STATUS_OFS;

    // A set in the same cycle as the clearing read wins.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            shake_flag_ff <= 1'b0;
            drop_flag_ff  <= 1'b0;
            tap_flag_ff   <= 1'b0;
        end else begin
            shake_flag_ff <= (shake_flag_ff && !status_rd) || (apply && stg_ev_ff[3]);
            drop_flag_ff  <= (drop_flag_ff && !status_rd) || (apply && stg_ev_ff[4]);
            tap_flag_ff   <= (tap_flag_ff && !status_rd) || (apply && stg_ev_ff[2]);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pl_ff <= 3'h0;
            fb_ff <= 2'h0;
        end else if (apply) begin
            pl_ff <= stg_pl_ff;
            fb_ff <= stg_fb_ff;
        end
    end

    // ------------------------------------------------------------
    // Interrupt pending and pin drive
    // ------------------------------------------------------------
    logic irq_pend_ff;
    logic irq_hit;

    always_comb begin
        irq_hit = apply && ((stg_ev_ff[0] && int_en_ff[msc_pkg::FB_IRQ_BIT])
                  || (stg_ev_ff[1] && int_en_ff[msc_pkg::ORIENT_IRQ_BIT])
                  || (stg_ev_ff[2] && int_en_ff[msc_pkg::TAP_IRQ_BIT])
                  || stg_ev_ff[3]
                  || (stg_ev_ff[4] && drop_ctl_ff[msc_pkg::DROP_IRQ_BIT])
                  || (stg_ev_ff[5] && int_en_ff[msc_pkg::SAMPLE_IRQ_BIT]));
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            irq_pend_ff <= 1'b0;
        end else begin
            irq_pend_ff <= (irq_pend_ff && !xfer_start) || irq_hit;
        end
    end

    logic active_high;
    logic push_pull;
    assign active_high = mode_ff[msc_pkg::ACTIVE_HIGH_BIT];
    assign push_pull   = mode_ff[msc_pkg::PUSH_PULL_BIT];

    always_comb begin
        irq_out_o  = irq_pend_ff ? active_high : !active_high;
        irq_out_oe = push_pull || irq_pend_ff;
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [7:0] op_status;
    always_comb begin
        op_status                        = 8'h00;
        op_status[1:0]                   = wake_ff ? msc_pkg::STATE_WAKE : msc_pkg::STATE_STANDBY;
        op_status[msc_pkg::NVM_BUSY_BIT] = nvm_active;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd_en) begin
            case (reg_addr)
                msc_pkg::MOTION_STATUS_OFS: begin
                    reg_rdata <= {shake_flag_ff, drop_flag_ff, tap_flag_ff, pl_ff, fb_ff};
                end
                msc_pkg::OP_STATE_STATUS_OFS: begin
                    reg_rdata <= op_status;
                end
                default: begin
                    reg_rdata <= 8'h00;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    state_code_a: assert property (
        op_status[1:0] == (wake_ff ? 2'h1 : 2'h3))
        else $error("Operating state code wrong.");
    status_zero_a: assert property (
        op_status[6:2] == 5'h00)
        else $error("Reserved status bits not zero.");
    wake_write_a: assert property (
        reg_wr_en && reg_addr == 8'h07 && reg_wdata[1:0] == 2'h1 |=> wake_ff)
        else $error("Wake request not taken.");
    standby_write_a: assert property (
        reg_wr_en && reg_addr == 8'h07 && reg_wdata[1:0] == 2'h3 |=> !wake_ff ##1 !tick_ff)
        else $error("Standby request not taken.");
    irq_clear_a: assert property (
        xfer_start && !irq_hit |=> !irq_pend_ff)
        else $error("Interrupt not cleared by access.");
    flag_hold_a: assert property (
        tap_flag_ff && !status_rd |=> tap_flag_ff)
        else $error("Tap flag dropped without read.");
    busy_freeze_a: assert property (
        xfer_busy |=> $stable(pl_ff) && $stable(fb_ff))
        else $error("Status changed during transfer.");
    drive_mode_a: assert property (
        !push_pull && !irq_pend_ff |-> !irq_out_oe)
        else $error("Open drain pin driven while idle.");
    polarity_a: assert property (
        irq_pend_ff |-> irq_out_o == active_high && irq_out_oe)
        else $error("Interrupt level wrong.");
    sample_irq_a: assert property (
        apply && stg_ev_ff[5] && int_en_ff[4] |=> irq_pend_ff)
        else $error("Sample interrupt missing.");
    tap_reject_a: assert property (
        tick_ff && run_ff > 5'({1'b0, tap_cnt_ff} + 5'h1) |-> !tap_now)
        else $error("Overlong tap accepted.");
endmodule

// File: msc_host_model.sv
// Host controller model that frames traffic on the serial bus pins.
module msc_host_model (
    output logic scl_line,
    output logic sda_line
);
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------
    // Idle bus
    // ------------------------------------------------------------
    // Both lines are pulled up, so an idle bus reads high and the clock stands still.
    initial begin
        scl_line = 1'b1;
        sda_line = 1'b1;
    end
    // ------------------------------------------------------------
    // Frame tasks
    // ------------------------------------------------------------
    // Opens a frame and clocks n bits; data moves only while the clock is low.
    task automatic begin_frame(int n);
        sda_line = 1'b0;
        #40;
        scl_line = 1'b0;
        repeat (n) begin
            #20;
            sda_line = ~sda_line;
            #20;
            scl_line = 1'b1;
            #40;
            scl_line = 1'b0;
        end
    endtask
    // Closes the frame, then leaves both lines released.
    task automatic end_frame();
        #20;
        sda_line = 1'b0;
        #20;
        scl_line = 1'b1;
        #40;
        sda_line = 1'b1;
        #40;
    endtask
endmodule

// File: tb_msc_ctrl_regs.sv
// Self-checking testbench of the motion sensor control register block.
module tb_msc_ctrl_regs;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int DIV = 20;
    logic       core_clk;
    logic       rst_n;
    logic       scl_in;
    logic       sda_in;
    logic [7:0] reg_addr;
    logic       reg_wr_en;
    logic [7:0] reg_wdata;
    logic       reg_rd_en;
    logic [7:0] reg_rdata;
    logic       nvm_active;
    logic [2:0] shake_evt;
    logic       drop_evt;
    logic [2:0] tap_above;
    logic [2:0] orient_code;
    logic [1:0] face_code;
    logic       sample_tick;
    logic       irq_out_o;
    logic       irq_out_oe;
    int         fails;
    int         comparisons;
    // ------------------------------------------------------------
    // Instances
    // ------------------------------------------------------------
    msc_ctrl_regs #(.SAMPLE_DIV(DIV)) u_dut (
        .core_clk(core_clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in),
        .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
        .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata), .nvm_active(nvm_active),
        .shake_evt(shake_evt), .drop_evt(drop_evt), .tap_above(tap_above),
        .orient_code(orient_code), .face_code(face_code), .sample_tick(sample_tick),
        .irq_out_o(irq_out_o), .irq_out_oe(irq_out_oe)
    );
    msc_host_model u_host (.scl_line(scl_in), .sda_line(sda_in));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge core_clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(negedge core_clk);
        reg_wr_en = 1'b0;
    endtask
    task automatic rd(string what, logic [7:0] a, logic [7:0] exp);
        @(negedge core_clk);
        reg_addr  = a;
        reg_rd_en = 1'b1;
        @(negedge core_clk);
        reg_rd_en = 1'b0;
        @(negedge core_clk);
        check(what, reg_rdata, exp);
    endtask
    task automatic pin(logic oe, logic o);
        check("irq drive", {7'h00, irq_out_oe}, {7'h00, oe});
        if (oe) check("irq level", {7'h00, irq_out_o}, {7'h00, o});
    endtask
    // Waits for n sample ticks, then lets the staged events land.
    task automatic ticks(int n);
        int k;
        repeat (n) begin
            k = 0;
            @(negedge core_clk);
            while (sample_tick !== 1'b1 && k < 4 * DIV) begin
                @(negedge core_clk);
                k++;
            end
            if (k >= 4 * DIV) check("sample tick", 8'h00, 8'h01);
        end
        repeat (3) @(negedge core_clk);
    endtask
    task automatic frame();
        u_host.begin_frame(9);
        u_host.end_frame();
        repeat (6) @(negedge core_clk);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        int k;
        pin(1'b0, 1'b0);
        rd("status", 8'h04, 8'h03);
        nvm_active = 1'b1;
        rd("status busy", 8'h04, 8'h83);
        nvm_active = 1'b0;
        rd("enable", 8'h06, 8'h00);
        rd("unmapped", 8'h20, 8'h00);
        k = 0;
        repeat (3 * DIV) begin
            @(negedge core_clk);
            if (sample_tick === 1'b1) k++;
        end
        check("standby ticks", 8'(k), 8'h00);
    endtask
    task automatic t_mode();
        wr(8'h07, 8'h01);
        rd("wake", 8'h04, 8'h01);
        wr(8'h07, 8'h00);
        rd("code 00", 8'h04, 8'h01);
        wr(8'h07, 8'h02);
        rd("code 10", 8'h04, 8'h01);
        wr(8'h07, 8'h03);
        rd("standby", 8'h04, 8'h03);
        wr(8'h07, 8'h01);
        ticks(1);
    endtask
    task automatic t_irq_pin();
        wr(8'h06, 8'h10);
        ticks(1);
        pin(1'b1, 1'b0);
        wr(8'h06, 8'h00);
        frame();
        pin(1'b0, 1'b0);
        wr(8'h07, 8'hC1);
        pin(1'b1, 1'b0);
        wr(8'h06, 8'h10);
        ticks(1);
        pin(1'b1, 1'b1);
        wr(8'h06, 8'h00);
        frame();
        pin(1'b1, 1'b0);
        wr(8'h07, 8'h41);
        pin(1'b1, 1'b1);
        wr(8'h07, 8'h01);
    endtask
    task automatic t_shake();
        for (int i = 0; i < 3; i++) begin
            wr(8'h06, 8'h80 >> i);
            shake_evt = 3'(1 << ((i + 1) % 3));
            ticks(1);
            shake_evt = 3'h0;
            pin(1'b0, 1'b0);
            rd("other axis", 8'h03, 8'h00);
            shake_evt = 3'(1 << i);
            ticks(1);
            shake_evt = 3'h0;
            pin(1'b1, 1'b0);
            frame();
            pin(1'b0, 1'b0);
            rd("shake held", 8'h03, 8'h80);
            rd("shake clear", 8'h03, 8'h00);
        end
        wr(8'h06, 8'h00);
    endtask
    task automatic t_drop();
        wr(8'h06, 8'h0F);
        drop_evt = 1'b1;
        ticks(1);
        drop_evt = 1'b0;
        pin(1'b0, 1'b0);
        rd("drop", 8'h03, 8'h40);
        wr(8'h0B, 8'h40);
        drop_evt = 1'b1;
        ticks(1);
        drop_evt = 1'b0;
        pin(1'b1, 1'b0);
        wr(8'h0B, 8'h00);
        wr(8'h06, 8'h00);
        frame();
        rd("drop irq", 8'h03, 8'h40);
    endtask
    task automatic tap_run(logic [2:0] a, int n, logic [7:0] exp, logic oe);
        ticks(1);
        tap_above = a;
        ticks(n);
        tap_above = 3'h0;
        ticks(1);
        pin(oe, 1'b0);
        rd("tap", 8'h03, exp);
        frame();
    endtask
    task automatic t_tap();
        wr(8'h09, 8'h20);
        wr(8'h0A, 8'h01);
        wr(8'h06, 8'h04);
        tap_run(3'h1, 2, 8'h20, 1'b1);
        tap_run(3'h1, 3, 8'h00, 1'b0);
        tap_run(3'h2, 2, 8'h00, 1'b0);
        wr(8'h09, 8'hE0);
        wr(8'h0A, 8'h0F);
        tap_run(3'h4, 16, 8'h20, 1'b1);
        wr(8'h0A, 8'h00);
        tap_run(3'h2, 1, 8'h20, 1'b1);
        wr(8'h06, 8'h00);
    endtask
    task automatic t_orient();
        wr(8'h06, 8'h02);
        orient_code = 3'h5;
        ticks(1);
        pin(1'b1, 1'b0);
        rd("orient", 8'h03, 8'h14);
        wr(8'h06, 8'h01);
        frame();
        face_code = 2'h1;
        ticks(1);
        pin(1'b1, 1'b0);
        frame();
        orient_code = 3'h6;
        ticks(1);
        pin(1'b0, 1'b0);
        rd("refresh", 8'h03, 8'h19);
        wr(8'h06, 8'h00);
        orient_code = 3'h0;
        face_code = 2'h0;
        ticks(1);
    endtask
    task automatic t_busy();
        wr(8'h06, 8'h80);
        u_host.begin_frame(4);
        shake_evt = 3'h1;
        ticks(1);
        shake_evt = 3'h0;
        rd("busy", 8'h03, 8'h00);
        pin(1'b0, 1'b0);
        u_host.end_frame();
        repeat (8) @(negedge core_clk);
        pin(1'b1, 1'b0);
        rd("after stop", 8'h03, 8'h80);
        wr(8'h06, 8'h00);
        frame();
    endtask
    // ------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        #100_000;
        fails++;
        give_verdict();
    end
    initial begin
        fails = 0;
        comparisons = 0;
        rst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wr_en = 1'b0;
        reg_wdata = 8'h00;
        reg_rd_en = 1'b0;
        nvm_active = 1'b0;
        shake_evt = 3'h0;
        drop_evt = 1'b0;
        tap_above = 3'h0;
        orient_code = 3'h0;
        face_code = 2'h0;
        repeat (4) @(negedge core_clk);
        rst_n = 1'b1;
        t_reset();
        t_mode();
        t_irq_pin();
        t_shake();
        t_drop();
        t_tap();
        t_orient();
        t_busy();
        give_verdict();
    end
endmodule
